// File: verilog/mdsc_pkg.sv
// Shared constants for the MAC-side delay and serial interface control block
package mdsc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_DELAY = 12'h602;
  localparam logic [11:0] IDX_CTRL = 12'h608;
  localparam logic [11:0] IDX_STATUS = 12'h60a;
  localparam logic [11:0] IDX_IRQ_STS = 12'h610;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h611;
  // Delay register fields
  localparam int DLY_TX_POS = 0;
  localparam int DLY_RX_POS = 1;
  // Control register fields
  localparam int CTL_AN_EN_POS = 0;
  localparam int CTL_TMR_POS = 1;
  localparam int CTL_TX_INV_POS = 7;
  localparam int CTL_RX_INV_POS = 8;
  localparam int CTL_EN_POS = 9;
  localparam int CTL_FVAL_POS = 10;
  localparam int CTL_FORCE_POS = 14;
  localparam int CTL_TXERR_DIS_POS = 15;
  localparam logic [15:0] CTL_RESET = 16'h007b;
  localparam logic [1:0] TMR_RESET = 2'h1;
  localparam logic AN_EN_RESET = 1'b1;
  // Interrupt status bits
  localparam int IRQ_PAGE = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_UP = 2;
  localparam int IRQ_DOWN = 3;
  localparam int IRQ_W = 4;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TMR_1P6MS_NS = 1600000;
  localparam int TMR_2US_NS = 2000;
  localparam int TMR_800US_NS = 800000;
  localparam int TMR_11MS_NS = 11000000;
  localparam int TMR_1P6MS_CYC = TMR_1P6MS_NS / CLK_PERIOD_NS;
  localparam int TMR_2US_CYC = TMR_2US_NS / CLK_PERIOD_NS;
  localparam int TMR_800US_CYC = TMR_800US_NS / CLK_PERIOD_NS;
  localparam int TMR_11MS_CYC = TMR_11MS_NS / CLK_PERIOD_NS;
  // Word alignment
  localparam logic [3:0] WORD_LAST_BIT = 4'h9;
  localparam logic [6:0] COMMA_POS = 7'b0011111;
  localparam logic [6:0] COMMA_NEG = 7'b1100000;
  localparam logic [1:0] SYNC_COMMAS = 2'h2;
  localparam logic [3:0] MISS_MAX = 4'hf;
  localparam logic [1:0] PAGE_MATCHES = 2'h2;
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
  typedef enum logic [3:0] {ST_LOSS, ST_CDET, ST_SYNC} mdsc_align_e;
endpackage : mdsc_pkg

// File: verilog/mdsc_sync.sv
// Two-flop synchroniser bank for pins from outside the core clock
`timescale 1ns/10ps
`default_nettype none
module mdsc_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_ff[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_ff[i] <= d[i];
        q[i] <= meta_ff[i];
      end
    end
  end
endmodule : mdsc_sync
`default_nettype wire

// File: verilog/mdsc_ctrl.sv
// Delay select, serial interface control and status with AHB-Lite access
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module mdsc_ctrl #(
  parameter int TMR_1P6MS = mdsc_pkg::TMR_1P6MS_CYC,
  parameter int TMR_800US = mdsc_pkg::TMR_800US_CYC,
  parameter int TMR_11MS = mdsc_pkg::TMR_11MS_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic link_clk,
  input wire logic link_rxd,
  input wire logic sgmii_en_strap,
  input wire logic tx_bit,
  input wire logic tx_err,
  output logic sgmii_txd,
  output logic sgmii_tx_err,
  output logic rgmii_rx_dly_en,
  output logic rgmii_tx_dly_en,
  output logic sgmii_active,
  output logic irq
);
  import mdsc_pkg::*;

  logic dp_valid_ff, dp_write_ff, rd_pend_ff;
  logic [11:0] dp_idx_ff;
  logic txerr_dis_ff, force_ff, en_ff, rx_inv_ff, tx_inv_ff, an_en_ff;
  logic [3:0] fval_ff;
  logic [1:0] tmr_sel_ff;
  logic [1:0] strap_cnt_ff;
  logic [IRQ_W-1:0] irq_sts_ff, irq_mask_ff, irq_evt;
  logic [2:0] pin_s;
  logic lclk_s, rxd_s, strap_s, lclk_d_ff, bit_stb, rx_bit;
  logic [9:0] sr_ff, word;
  logic [3:0] phase_ff, idx_ff, sel_idx;
  logic comma, wb, hit;
  mdsc_align_e state_ff;
  logic [1:0] good_ff;
  logic [3:0] miss_ff;
  logic prev_comma_ff, page_ff, done_ff, link_up_ff;
  logic [9:0] last_cfg_ff;
  logic [1:0] match_ff;
  logic [19:0] tmr_ff, tmr_lim;
  logic an_clr, wr_ctrl, wr_dly, wr_msk, wr_sts;
  logic [15:0] ctrl_rd, stat_rd;

  mdsc_sync #(.W(3)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({sgmii_en_strap, link_rxd, link_clk}),
    .q(pin_s)
  );
  assign lclk_s = pin_s[0];
  assign rxd_s = pin_s[1];
  assign strap_s = pin_s[2];

  // Bus slave: writes take no wait, reads take one so the data is a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_idx_ff <= 12'h000;
      rd_pend_ff <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else begin
      rd_pend_ff <= 1'b0;
      if (hready) begin
        dp_valid_ff <= hsel & htrans[1];
        dp_write_ff <= hwrite;
        dp_idx_ff <= haddr[13:2];
        if (hsel & htrans[1] & !hwrite) begin
          hreadyout <= 1'b0;
          rd_pend_ff <= 1'b1;
        end
      end
      if (rd_pend_ff) begin
        hreadyout <= 1'b1;
        case (dp_idx_ff)
          IDX_DELAY: hrdata <= {30'h0, rgmii_rx_dly_en, rgmii_tx_dly_en};
          IDX_CTRL: hrdata <= {16'h0000, ctrl_rd};
          IDX_STATUS: hrdata <= {16'h0000, stat_rd};
          IDX_IRQ_STS: hrdata <= {28'h0, irq_sts_ff};
          IDX_IRQ_MASK: hrdata <= {28'h0, irq_mask_ff};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign hresp = 1'b0;

  assign wr_ctrl = dp_valid_ff & dp_write_ff & (dp_idx_ff == IDX_CTRL);
  assign wr_dly = dp_valid_ff & dp_write_ff & (dp_idx_ff == IDX_DELAY);
  assign wr_sts = dp_valid_ff & dp_write_ff & (dp_idx_ff == IDX_IRQ_STS);
  assign wr_msk = dp_valid_ff & dp_write_ff & (dp_idx_ff == IDX_IRQ_MASK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rgmii_rx_dly_en <= 1'b0;
      rgmii_tx_dly_en <= 1'b0;
    end else if (wr_dly) begin
      rgmii_rx_dly_en <= hwdata[DLY_RX_POS];
      rgmii_tx_dly_en <= hwdata[DLY_TX_POS];
    end
  end

  // Strap is caught once the synchroniser holds a settled value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_cnt_ff <= 2'h0;
    end else if (strap_cnt_ff != 2'h3) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txerr_dis_ff <= CTL_RESET[CTL_TXERR_DIS_POS];
      force_ff <= CTL_RESET[CTL_FORCE_POS];
      fval_ff <= CTL_RESET[CTL_FVAL_POS +: 4];
      en_ff <= 1'b0;
      rx_inv_ff <= CTL_RESET[CTL_RX_INV_POS];
      tx_inv_ff <= CTL_RESET[CTL_TX_INV_POS];
      tmr_sel_ff <= TMR_RESET;
      an_en_ff <= AN_EN_RESET;
    end else if (strap_cnt_ff == STRAP_LOAD_CNT) begin
      en_ff <= strap_s;
    end else if (wr_ctrl) begin
      txerr_dis_ff <= hwdata[CTL_TXERR_DIS_POS];
      force_ff <= hwdata[CTL_FORCE_POS];
      fval_ff <= hwdata[CTL_FVAL_POS +: 4];
      en_ff <= hwdata[CTL_EN_POS];
      rx_inv_ff <= hwdata[CTL_RX_INV_POS];
      tx_inv_ff <= hwdata[CTL_TX_INV_POS];
      tmr_sel_ff <= hwdata[CTL_TMR_POS +: 2];
      an_en_ff <= hwdata[CTL_AN_EN_POS];
    end
  end

  assign ctrl_rd = {txerr_dis_ff, force_ff, fval_ff, en_ff, rx_inv_ff,
                    tx_inv_ff, 4'h0, tmr_sel_ff, an_en_ff};
  assign stat_rd = {3'h0, page_ff, link_up_ff, done_ff,
                    state_ff != ST_LOSS, state_ff == ST_SYNC,
                    sel_idx, state_ff};

  // Transmit side, gated off while the serial path is disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sgmii_txd <= 1'b0;
      sgmii_tx_err <= 1'b0;
      sgmii_active <= 1'b0;
    end else begin
      sgmii_active <= en_ff;
      sgmii_txd <= en_ff & (tx_bit ^ tx_inv_ff);
      sgmii_tx_err <= en_ff & tx_err & !txerr_dis_ff;
    end
  end

  // Link clock edge finder on the synchronised level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lclk_d_ff <= 1'b0;
    end else begin
      lclk_d_ff <= lclk_s;
    end
  end
  assign bit_stb = lclk_s & !lclk_d_ff & en_ff;
  assign rx_bit = rxd_s ^ rx_inv_ff;
  assign word = {sr_ff[8:0], rx_bit};
  assign comma = (word[9:3] == COMMA_POS) || (word[9:3] == COMMA_NEG);
  assign sel_idx = force_ff ? fval_ff : idx_ff;
  assign wb = bit_stb & (phase_ff == sel_idx);
  // Free search only while unforced and out of alignment
  assign hit = bit_stb & !force_ff & (state_ff == ST_LOSS) & comma;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr_ff <= 10'h000;
      phase_ff <= 4'h0;
      idx_ff <= 4'h0;
    end else if (bit_stb) begin
      sr_ff <= word;
      phase_ff <= (phase_ff == WORD_LAST_BIT) ? 4'h0 : phase_ff + 4'h1;
      if (hit) begin
        idx_ff <= phase_ff;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_LOSS;
      good_ff <= 2'h0;
      miss_ff <= 4'h0;
    end else if (!en_ff) begin
      state_ff <= ST_LOSS;
    end else begin
      case (state_ff)
        ST_LOSS: begin
          good_ff <= 2'h1;
          miss_ff <= 4'h0;
          if (hit || (wb && force_ff && comma)) begin
            state_ff <= ST_CDET;
          end
        end
        ST_CDET, ST_SYNC: begin
          if (wb && comma) begin
            miss_ff <= 4'h0;
            if (good_ff == SYNC_COMMAS) begin
              state_ff <= ST_SYNC;
            end else begin
              good_ff <= good_ff + 2'h1;
            end
          end else if (wb) begin
            miss_ff <= miss_ff + 4'h1;
            if (miss_ff == MISS_MAX) begin
              state_ff <= ST_LOSS;
            end
          end
        end
        default: state_ff <= ST_LOSS;
      endcase
    end
  end

  // Page: a non-zero word after a comma seen four times running
  assign an_clr = (state_ff != ST_SYNC) | !an_en_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_comma_ff <= 1'b0;
      last_cfg_ff <= 10'h000;
      match_ff <= 2'h0;
      page_ff <= 1'b0;
    end else if (an_clr) begin
      prev_comma_ff <= 1'b0;
      match_ff <= 2'h0;
      page_ff <= 1'b0;
    end else if (wb) begin
      prev_comma_ff <= comma;
      if (prev_comma_ff) begin
        last_cfg_ff <= word;
        if (word != last_cfg_ff) begin
          match_ff <= 2'h0;
        end else if (match_ff != PAGE_MATCHES) begin
          match_ff <= match_ff + 2'h1;
        end else if (word != 10'h000) begin
          page_ff <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    case (tmr_sel_ff)
      2'h0: tmr_lim = 20'(TMR_1P6MS);
      2'h1: tmr_lim = 20'(TMR_2US_CYC);
      2'h2: tmr_lim = 20'(TMR_800US);
      default: tmr_lim = 20'(TMR_11MS);
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_ff <= 20'h00000;
      done_ff <= 1'b0;
    end else if (an_clr || !page_ff) begin
      tmr_ff <= 20'h00000;
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      tmr_ff <= tmr_ff + 20'h00001;
      if (tmr_ff == tmr_lim - 20'h00001) begin
        done_ff <= 1'b1;
      end
    end
  end

  // Without negotiation the link follows sync alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_up_ff <= 1'b0;
    end else begin
      link_up_ff <= (state_ff == ST_SYNC) & (done_ff | !an_en_ff);
    end
  end

  logic page_d_ff, done_d_ff, up_d_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_d_ff <= 1'b0;
      done_d_ff <= 1'b0;
      up_d_ff <= 1'b0;
    end else begin
      page_d_ff <= page_ff;
      done_d_ff <= done_ff;
      up_d_ff <= link_up_ff;
    end
  end
  // Rising edges of the status flags, and the falling edge of link up
  assign irq_evt[IRQ_PAGE] = !page_d_ff & page_ff;
  assign irq_evt[IRQ_DONE] = !done_d_ff & done_ff;
  assign irq_evt[IRQ_UP] = !up_d_ff & link_up_ff;
  assign irq_evt[IRQ_DOWN] = up_d_ff & !link_up_ff;

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sts_ff <= 4'h0;
      irq_mask_ff <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_sts_ff <= (irq_sts_ff & ~({4{wr_sts}} & hwdata[IRQ_W-1:0]))
                    | irq_evt;
      if (wr_msk) begin
        irq_mask_ff <= hwdata[IRQ_W-1:0];
      end
      irq <= |(irq_sts_ff & irq_mask_ff);
    end
  end

  AST_RXDLY: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_dly |=> rgmii_rx_dly_en == $past(hwdata[DLY_RX_POS]))
    else $error("rx delay enable not taken from write");
  AST_TXDLY: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_dly |=> rgmii_tx_dly_en == $past(hwdata[DLY_TX_POS]))
    else $error("tx delay enable not taken from write");
  AST_TXERR: assert property (@(posedge hclk) disable iff (!hresetn)
    txerr_dis_ff |=> !sgmii_tx_err)
    else $error("tx error shown while suppressed");
  AST_FORCE: assert property (@(posedge hclk) disable iff (!hresetn)
    force_ff && bit_stb |=> idx_ff == $past(idx_ff))
    else $error("search moved index while forced");
  AST_RXINV: assert property (@(posedge hclk) disable iff (!hresetn)
    bit_stb |=> sr_ff[0] == ($past(rxd_s) ^ $past(rx_inv_ff)))
    else $error("rx bit not inverted as set");
  AST_TXINV: assert property (@(posedge hclk) disable iff (!hresetn)
    en_ff |=> sgmii_txd == ($past(tx_bit) ^ $past(tx_inv_ff)))
    else $error("tx bit polarity wrong");
  AST_LINK: assert property (@(posedge hclk) disable iff (!hresetn)
    link_up_ff |-> $past(state_ff == ST_SYNC))
    else $error("link up without sync");
  AST_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(done_ff) |-> $past(page_ff) && $past(an_en_ff))
    else $error("negotiation done without page");
  AST_RSV: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_ff && dp_idx_ff == IDX_STATUS |=> hrdata[31:13] == 19'h0)
    else $error("reserved status bits not zero");
endmodule : mdsc_ctrl
`default_nettype wire

// File: verification/mdsc_link_model.sv
// Far-end serial link model: bit clock and receive data
`timescale 1ns/10ps
`default_nettype none
module mdsc_link_model (
  output logic link_clk,
  output logic link_rxd
);
  logic busy;
  initial begin
    link_clk = 1'b0;
    link_rxd = 1'b0;
    busy = 1'b0;
  end
  // Idle line keeps toggling so a stale bit never looks held
  always #130 if (!busy) link_rxd = ~link_rxd;
  // Clock runs only inside a word, msb first, 200 ns a bit
  task automatic send_word(input logic [9:0] w);
    busy = 1'b1;
    #7;
    for (int i = 9; i >= 0; i--) begin
      link_rxd = w[i];
      #100 link_clk = 1'b1;
      #100 link_clk = 1'b0;
    end
    busy = 1'b0;
  endtask : send_word
endmodule : mdsc_link_model
`default_nettype wire

// File: verification/mac_if_delay_sgmii_ctrl_tb_top.sv
// Self-checking bench for the delay and serial interface control block
`timescale 1ns/10ps
`default_nettype none
module mac_if_delay_sgmii_ctrl_tb_top;
  import mdsc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, tx_bit, tx_err, strap;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hreadyout, hresp, link_clk, link_rxd, txd, txe;
  wire logic rx_dly, tx_dly, active, irq;
  wire logic [31:0] hrdata;
  int err_count, checks;
  localparam logic [9:0] COMMA_W = 10'h0fa;
  localparam logic [9:0] PAGE_W = 10'h155;

  // Short timer values keep the run brief
  mdsc_ctrl #(.TMR_1P6MS(100), .TMR_800US(50), .TMR_11MS(200)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link_clk(link_clk), .link_rxd(link_rxd),
    .sgmii_en_strap(strap), .tx_bit(tx_bit), .tx_err(tx_err),
    .sgmii_txd(txd), .sgmii_tx_err(txe), .rgmii_rx_dly_en(rx_dly),
    .rgmii_tx_dly_en(tx_dly), .sgmii_active(active), .irq(irq));

  mdsc_link_model link_u (.link_clk(link_clk), .link_rxd(link_rxd));

  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // Old value of hreadyout is read at the edge, before it updates
  task automatic wait_rdy();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : wait_rdy

  task automatic bus(input logic [11:0] idx, input logic wr,
    input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic t_reset();
    rchk(IDX_CTRL, 32'h0203);
    rchk(IDX_DELAY, 32'h0);
    chk(32'(active), 32'h1);
    chk(32'({rx_dly, tx_dly}), 32'h0);
    bus(IDX_STATUS, 1'b1, 32'hffff);
    rchk(IDX_STATUS, 32'h0);
    bus(12'h700, 1'b1, 32'hffff);
    rchk(12'h700, 32'h0);
  endtask : t_reset

  task automatic t_delay();
    bus(IDX_DELAY, 1'b1, 32'hffff);
    rchk(IDX_DELAY, 32'h3);
    chk(32'({rx_dly, tx_dly}), 32'h3);
    bus(IDX_DELAY, 1'b1, 32'h2);
    cyc(2);
    chk(32'({rx_dly, tx_dly}), 32'h2);
    bus(IDX_DELAY, 1'b1, 32'h1);
    cyc(2);
    chk(32'({rx_dly, tx_dly}), 32'h1);
  endtask : t_delay

  // Every mix of transmit invert and error suppression, each timer code
  task automatic t_tx();
    logic [15:0] v;
    for (int k = 0; k < 4; k++) begin
      v = 16'h0201 | {k[1], 7'h0, k[0], 4'h0, 2'(k), 1'b0};
      bus(IDX_CTRL, 1'b1, {16'h0, v | 16'h0078});
      rchk(IDX_CTRL, {16'h0, v});
      cyc(2);
      chk(32'(txd), 32'(!k[0]));
      chk(32'(txe), 32'(!k[1]));
    end
    bus(IDX_CTRL, 1'b1, 32'h0003);
    cyc(2);
    chk(32'({active, txd, txe}), 32'h0);
  endtask : t_tx

  // Index above the word length never matches, so no lock
  task automatic t_force();
    bus(IDX_CTRL, 1'b1, 32'h7303);
    repeat (6) link_u.send_word(COMMA_W);
    cyc(10);
    rchk(IDX_STATUS, 32'h00c0);
  endtask : t_force

  task automatic t_link();
    bus(IDX_CTRL, 1'b1, 32'h0203);
    repeat (12) begin
      link_u.send_word(COMMA_W);
      link_u.send_word(PAGE_W);
    end
    cyc(200);
    bus(IDX_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h1f0f, 32'h1f02);
    chk(32'(irq), 32'h0);
    rchk(IDX_IRQ_STS, 32'h7);
    bus(IDX_IRQ_MASK, 1'b1, 32'h4);
    cyc(3);
    chk(32'(irq), 32'h1);
    bus(IDX_IRQ_STS, 1'b1, 32'h7);
    cyc(3);
    chk(32'(irq), 32'h0);
    rchk(IDX_IRQ_STS, 32'h0);
    bus(IDX_CTRL, 1'b1, 32'h0202);
    cyc(3);
    bus(IDX_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h1900, 32'h0900);
    bus(IDX_CTRL, 1'b1, 32'h0);
    cyc(3);
    bus(IDX_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h190f, 32'h0);
    bus(IDX_IRQ_STS, 1'b0, 32'h0);
    chk(rd & 32'h8, 32'h8);
  endtask : t_link

  task automatic close_out();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial begin
    #2000000;
    err_count++;
    close_out();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    tx_bit = 1'b1;
    tx_err = 1'b1;
    strap = 1'b1;
    cyc(2);
    hresetn <= 1'b1;
    cyc(4);
    t_reset();
    t_delay();
    t_tx();
    t_force();
    t_link();
    close_out();
  end
endmodule : mac_if_delay_sgmii_ctrl_tb_top
`default_nettype wire
